// >>> hw/spoc_pkg.sv
// Shared constants for the aux reference output and phase configuration
// ============================================================
// Register map
// ============================================================
package spoc_pkg;
   localparam logic [7:0] ADDR_BANK_A = 8'h00;
   localparam logic [7:0] ADDR_BANK_B = 8'h04;
   localparam logic [7:0] ADDR_AUX_CFG = 8'h08;
   localparam logic [7:0] ADDR_SR_CFG = 8'h0C;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // ============================================================
   // Field layout
   // ============================================================
   localparam int BANK_RATIO_LSB = 0;
   localparam int BANK_DELAY_LSB = 8;
   localparam int AUX_FIELD_W = 8;
   localparam int AUX_FSEL_BIT = 0;
   localparam int AUX_DRIVE_BIT = 1;
   localparam int AUX_SWING_LSB = 2;
   localparam int AUX_SLEEP_BIT = 4;
   localparam int AUX_FINE_LSB = 5;
   localparam int SR_STYLE_BIT = 0;
   localparam int SR_RATE_LSB = 1;
   localparam int SR_COUNT_LSB = 8;
   localparam int CMD_SYNC_BIT = 0;
   localparam int CMD_SR_REQ_BIT = 1;
   // ============================================================
   // Reset values and sizes
   // ============================================================
   localparam logic [6:0] BANK_RATIO_RST = 7'h01;
   localparam logic [5:0] BANK_DELAY_RST = 6'h00;
   localparam logic [7:0] AUX_CFG_RST = 8'h10;
   localparam logic [7:0] SR_COUNT_RST = 8'h01;
   localparam int NUM_AUX = 4;
   localparam int COARSE_STEPS = 64;
   localparam int FINE_STEPS = 4;
   localparam int SR_DIV_W = 12;
   localparam logic [1:0] SWING_OFF = 2'h0;
   localparam logic [1:0] SWING_SYSREF = 2'h1;

   typedef enum logic [0:0] {
      SR_SLEEP = 1'b0,
      SR_RUN = 1'b1
   } spoc_sr_state_type;

   // Rate code to SYSREF divide ratio; unused codes fall to the slowest
   function automatic logic [SR_DIV_W-1:0] sr_ratio(input logic [3:0] code);
      unique case (code)
         4'h0: sr_ratio = 12'h040;
         4'h1: sr_ratio = 12'h060;
         4'h2: sr_ratio = 12'h080;
         4'h3: sr_ratio = 12'h0C0;
         4'h4: sr_ratio = 12'h100;
         4'h5: sr_ratio = 12'h180;
         4'h6: sr_ratio = 12'h200;
         4'h7: sr_ratio = 12'h300;
         4'h8: sr_ratio = 12'h400;
         default: sr_ratio = 12'h800;
      endcase
   endfunction
endpackage

// >>> hw/spoc_divider.sv
// Restartable integer divider producing a square level and a wrap pulse
`timescale 1ns/1ps
`default_nettype none
module spoc_divider #(
   parameter int W = 7
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic restart_in,
   input wire logic [W-1:0] ratio_in,
   output logic level_out,
   output logic wrap_out
);
   logic [W-1:0] count_q;
   logic [W-1:0] last;
   logic [W-1:0] half;

   // Ratio 0 behaves as ratio 1
   always_comb begin
      last = (ratio_in == '0) ? '0 : ratio_in - W'(1);
      // Extra bit keeps the top ratio from wrapping to a zero half
      half = (ratio_in == '0) ? W'(1)
           : W'(({1'b0, ratio_in} + {{W{1'b0}}, 1'b1}) >> 1);
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in || restart_in) begin
         count_q <= '0;
      end else if (count_q >= last) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + W'(1);
      end
   end

   assign level_out = (count_q < half);
   assign wrap_out = (count_q >= last);
endmodule // spoc_divider
`default_nettype wire

// >>> hw/spoc_tap_delay.sv
// Shift line with a selectable tap, one clock period per step
`timescale 1ns/1ps
`default_nettype none
module spoc_tap_delay #(
   parameter int DEPTH = 64,
   parameter int SW = 6
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic d_in,
   input wire logic [SW-1:0] sel_in,
   output logic q_out
);
   logic [DEPTH-1:0] line_q;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         line_q <= '0;
      end else begin
         line_q <= {line_q[DEPTH-2:0], d_in};
      end
   end

   // Tap 0 bypasses the line entirely
   assign q_out = (sel_in == '0) ? d_in : line_q[sel_in - SW'(1)];
endmodule // spoc_tap_delay
`default_nettype wire

// >>> hw/spoc_top.sv
// Aux reference output function, power and phase delay control
// How it works
// - see: per-output select, 0 clock, 1 SYSREF
// - see: clock function uses bank divider frequency
// - see: clock function uses bank coarse delay
// - see: swing 00 powers buffer down always
// - see: clock, enable 0, swing nonzero: low
// - see: enable 1 toggles; swing sets level
// - see: sleep bit powers down fine delay
// - see: counted style idle powers SYSREF down
// - see: SYSREF request with count nonzero powers outputs back up
// - see: divider sync aligns all clock outputs
// - see: coarse delay 0..63 whole VCO periods
// - see: each SYSREF output has 3-bit fine delay
// - see: upper bits periods, low bit buffer
// - see: equal fine codes give aligned edges
// - see: counted 1..255 pulses, count 0 none; style 1 free-running
`timescale 1ns/1ps
`default_nettype none
module spoc_top (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic [1:0] device_clock_output_out,
   output logic [3:0] aux_reference_output_out,
   output logic [3:0] aux_buffer_on_out,
   output logic [7:0] aux_swing_out,
   output logic [3:0] aux_delay_powered_out,
   output logic [3:0] aux_fine_buffer_out
);
   // ============================================================
   // Register bus
   // ============================================================
   logic ack_q;
   logic [31:0] rdata_q;
   logic [6:0] ratio_q [2];
   logic [5:0] coarse_q [2];
   logic [31:0] aux_cfg_q;
   logic sr_style_q;
   logic [3:0] sr_rate_q;
   logic [7:0] sr_count_q;
   logic sync_pulse_q;
   logic sr_req_q;
   logic wr_en;
   logic [31:0] wmask;
   logic [31:0] rd_mux;
   spoc_pkg::spoc_sr_state_type sr_state_q;
   logic [7:0] sr_left_q;
   logic sr_level;
   logic sr_wrap;
   logic sr_base;
   logic sr_awake;

   assign wr_en = wb_cyc_in && wb_stb_in && wb_we_in && !ack_q;
   assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                   {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

   // One wait cycle, ack stands one cycle
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_in && wb_stb_in && !ack_q;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (wb_adr_in)
         spoc_pkg::ADDR_BANK_A: begin
            rd_mux[spoc_pkg::BANK_RATIO_LSB +: 7] = ratio_q[0];
            rd_mux[spoc_pkg::BANK_DELAY_LSB +: 6] = coarse_q[0];
         end
         spoc_pkg::ADDR_BANK_B: begin
            rd_mux[spoc_pkg::BANK_RATIO_LSB +: 7] = ratio_q[1];
            rd_mux[spoc_pkg::BANK_DELAY_LSB +: 6] = coarse_q[1];
         end
         spoc_pkg::ADDR_AUX_CFG: rd_mux = aux_cfg_q;
         spoc_pkg::ADDR_SR_CFG: begin
            rd_mux[spoc_pkg::SR_STYLE_BIT] = sr_style_q;
            rd_mux[spoc_pkg::SR_RATE_LSB +: 4] = sr_rate_q;
            rd_mux[spoc_pkg::SR_COUNT_LSB +: 8] = sr_count_q;
         end
         spoc_pkg::ADDR_STATUS: begin
            rd_mux[0] = (sr_state_q == spoc_pkg::SR_RUN);
            rd_mux[1] = sr_awake;
            rd_mux[15:8] = sr_left_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (wb_cyc_in && wb_stb_in && !wb_we_in && !ack_q) begin
         rdata_q <= rd_mux;
      end
   end

   // Each field is written only when the byte lane bit that holds it is set
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ratio_q[0] <= spoc_pkg::BANK_RATIO_RST;
         ratio_q[1] <= spoc_pkg::BANK_RATIO_RST;
         coarse_q[0] <= spoc_pkg::BANK_DELAY_RST;
         coarse_q[1] <= spoc_pkg::BANK_DELAY_RST;
         aux_cfg_q <= {spoc_pkg::NUM_AUX{spoc_pkg::AUX_CFG_RST}};
         sr_style_q <= 1'b0;
         sr_rate_q <= 4'h0;
         sr_count_q <= spoc_pkg::SR_COUNT_RST;
      end else if (wr_en) begin
         unique case (wb_adr_in)
            spoc_pkg::ADDR_BANK_A: begin
               if (wb_sel_in[0]) ratio_q[0] <= wb_dat_in[6:0];
               if (wb_sel_in[1]) coarse_q[0] <= wb_dat_in[13:8];
            end
            spoc_pkg::ADDR_BANK_B: begin
               if (wb_sel_in[0]) ratio_q[1] <= wb_dat_in[6:0];
               if (wb_sel_in[1]) coarse_q[1] <= wb_dat_in[13:8];
            end
            spoc_pkg::ADDR_AUX_CFG: begin
               aux_cfg_q <= (aux_cfg_q & ~wmask) | (wb_dat_in & wmask);
            end
            spoc_pkg::ADDR_SR_CFG: begin
               if (wb_sel_in[0]) sr_style_q <= wb_dat_in[0];
               if (wb_sel_in[0]) sr_rate_q <= wb_dat_in[4:1];
               if (wb_sel_in[1]) sr_count_q <= wb_dat_in[15:8];
            end
            default: begin
            end
         endcase
      end
   end

   // Command strobes, one cycle each
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         sync_pulse_q <= 1'b0;
         sr_req_q <= 1'b0;
      end else begin
         sync_pulse_q <= wr_en && wb_sel_in[0]
                         && (wb_adr_in == spoc_pkg::ADDR_CMD)
                         && wb_dat_in[spoc_pkg::CMD_SYNC_BIT];
         sr_req_q <= wr_en && wb_sel_in[0]
                     && (wb_adr_in == spoc_pkg::ADDR_CMD)
                     && wb_dat_in[spoc_pkg::CMD_SR_REQ_BIT];
      end
   end

   // ============================================================
   // Bank dividers and coarse delay
   // ============================================================
   logic [1:0] bank_div;
   logic [1:0] bank_del;

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         // Common restart gives all banks one incident rising edge
         spoc_divider #(.W(7)) u_div (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .restart_in(sync_pulse_q),
            .ratio_in(ratio_q[b]),
            .level_out(bank_div[b]),
            .wrap_out()
         );
         spoc_tap_delay #(.DEPTH(spoc_pkg::COARSE_STEPS - 1), .SW(6)) u_del (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .d_in(bank_div[b]),
            .sel_in(coarse_q[b]),
            .q_out(bank_del[b])
         );
      end
   endgenerate

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         device_clock_output_out <= 2'h0;
      end else begin
         device_clock_output_out <= bank_del;
      end
   end

   // ============================================================
   // SYSREF generator
   // ============================================================
   spoc_divider #(.W(spoc_pkg::SR_DIV_W)) u_sr_div (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .restart_in(sr_req_q),
      .ratio_in(spoc_pkg::sr_ratio(sr_rate_q)),
      .level_out(sr_level),
      .wrap_out(sr_wrap)
   );

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         sr_state_q <= spoc_pkg::SR_SLEEP;
         sr_left_q <= 8'h00;
      end else if (sr_req_q) begin
         if (sr_style_q || sr_count_q != 8'h00) begin
            sr_state_q <= spoc_pkg::SR_RUN;
         end else begin
            sr_state_q <= spoc_pkg::SR_SLEEP;
         end
         sr_left_q <= sr_count_q;
      end else begin
         unique case (sr_state_q)
            spoc_pkg::SR_SLEEP: sr_left_q <= 8'h00;
            spoc_pkg::SR_RUN: begin
               // Counted style stops itself after the last pulse
               if (sr_wrap && !sr_style_q) begin
                  sr_left_q <= sr_left_q - 8'h01;
                  if (sr_left_q <= 8'h01) begin
                     sr_state_q <= spoc_pkg::SR_SLEEP;
                  end
               end
            end
         endcase
      end
   end

   // Continuous style never sleeps on its own
   assign sr_awake = sr_style_q
                     || (sr_state_q == spoc_pkg::SR_RUN);
   assign sr_base = (sr_state_q == spoc_pkg::SR_RUN) && sr_level;

   // ============================================================
   // Aux outputs
   // ============================================================
   logic [3:0] fsel;
   logic [3:0] drive_on;
   logic [3:0] sleep;
   logic [1:0] swing [4];
   logic [2:0] fine [4];
   logic [3:0] sr_del;
   logic [3:0] src;

   genvar i;
   generate
      for (i = 0; i < spoc_pkg::NUM_AUX; i++) begin : g_aux
         localparam int BASE = i * spoc_pkg::AUX_FIELD_W;
         assign fsel[i] = aux_cfg_q[BASE + spoc_pkg::AUX_FSEL_BIT];
         assign drive_on[i] = aux_cfg_q[BASE + spoc_pkg::AUX_DRIVE_BIT];
         assign sleep[i] = aux_cfg_q[BASE + spoc_pkg::AUX_SLEEP_BIT];
         assign swing[i] = aux_cfg_q[BASE + spoc_pkg::AUX_SWING_LSB +: 2];
         assign fine[i] = aux_cfg_q[BASE + spoc_pkg::AUX_FINE_LSB +: 3];

         // Same shared source, same tap: equal codes stay aligned
         spoc_tap_delay #(.DEPTH(spoc_pkg::FINE_STEPS - 1), .SW(2)) u_fine (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .d_in(sr_base),
            .sel_in(fine[i][2:1]),
            .q_out(sr_del[i])
         );

         // Outputs 0,1 belong to bank A, 2,3 to bank B
         assign src[i] = fsel[i] ? sr_del[i]
                                 : bank_del[i / 2];

         always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
               aux_reference_output_out[i] <= 1'b0;
               aux_buffer_on_out[i] <= 1'b0;
               aux_swing_out[2*i +: 2] <= spoc_pkg::SWING_OFF;
               aux_delay_powered_out[i] <= 1'b0;
               aux_fine_buffer_out[i] <= 1'b0;
            end else begin
               // Disabled or unpowered outputs sit low
               aux_reference_output_out[i] <= drive_on[i]
                  && swing[i] != spoc_pkg::SWING_OFF
                  && (!fsel[i] || sr_awake) && src[i];
               aux_buffer_on_out[i] <= swing[i] != spoc_pkg::SWING_OFF
                  && (!fsel[i] || sr_awake);
               aux_swing_out[2*i +: 2] <= swing[i];
               aux_delay_powered_out[i] <= !sleep[i];
               // Sub-period step is a buffer outside this clock domain
               aux_fine_buffer_out[i] <= fsel[i] && fine[i][0];
            end
         end

         // ======== checks ========
         a_swing_off_down: assert property (@(posedge clk_in)
            disable iff (!reset_n_in)
            swing[i] == spoc_pkg::SWING_OFF |=> !aux_buffer_on_out[i])
            else $error("buffer on with swing off");
         a_disabled_low: assert property (@(posedge clk_in)
            disable iff (!reset_n_in)
            !drive_on[i] |=> !aux_reference_output_out[i])
            else $error("disabled output not low");
         a_clock_follows_bank: assert property (@(posedge clk_in)
            disable iff (!reset_n_in)
            (!fsel[i] && drive_on[i] && swing[i] != 2'h0)
            |=> aux_reference_output_out[i] == $past(bank_del[i / 2]))
            else $error("clock aux not following its bank");
         a_sleep_delay_off: assert property (@(posedge clk_in)
            disable iff (!reset_n_in)
            sleep[i] |=> !aux_delay_powered_out[i])
            else $error("fine delay powered while asleep");
      end
   endgenerate

   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdata_q;

   // ============================================================
   // Checks
   // ============================================================
   a_ack_one_cycle: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   a_ack_after_req: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
      else $error("request not answered next cycle");
   a_auto_sleep: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (!sr_style_q && sr_state_q == spoc_pkg::SR_SLEEP)
      |=> (aux_buffer_on_out & $past(fsel)) == 4'h0)
      else $error("counted SYSREF awake while idle");
   a_wake_on_req: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (sr_req_q && sr_count_q != 8'h00) |=> sr_state_q == spoc_pkg::SR_RUN)
      else $error("SYSREF request did not wake outputs");
   a_sync_restart: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      sync_pulse_q |=> bank_div == 2'h3)
      else $error("banks not on common rising edge after sync");
   a_single_pulse: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (sr_state_q == spoc_pkg::SR_RUN && !sr_style_q && sr_left_q == 8'h01
       && sr_wrap && !sr_req_q) |=> sr_state_q == spoc_pkg::SR_SLEEP)
      else $error("counted SYSREF did not stop after last pulse");
   a_coarse_zero: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      coarse_q[0] == 6'h00 |-> bank_del[0] == bank_div[0])
      else $error("coarse setting 0 inserted delay");
endmodule // spoc_top
`default_nettype wire

// >>> testbench/spoc_conv_model.sv
// Receiving converter model: counts the edges it can see on each line
`timescale 1ns/1ps
`default_nettype none
module spoc_conv_model (
   input wire logic clk_in,
   input wire logic clear_in,
   input wire logic [5:0] line_in,
   input wire logic [3:0] buffer_on_in
);
   // ============================================================
   // Edge bookkeeping
   // ============================================================
   int rises [6];
   int first [6];
   int both;
   int now;
   logic [5:0] line_q;
   logic [5:0] seen;
   // A powered-down buffer shows nothing, whatever its data bit says
   assign seen = line_in & {2'b11, buffer_on_in};
   always_ff @(posedge clk_in) begin
      line_q <= seen;
      now <= now + 1;
      if (clear_in) begin
         both <= 0;
      end else if (seen[5:4] == 2'b11 && line_q[5:4] == 2'b00) begin
         both <= both + 1;
      end
      for (int i = 0; i < 6; i++) begin
         if (clear_in) begin
            rises[i] <= 0;
            first[i] <= -1;
         end else if (seen[i] && !line_q[i]) begin
            rises[i] <= rises[i] + 1;
            if (first[i] < 0) begin
               first[i] <= now;
            end
         end
      end
   end
endmodule // spoc_conv_model
`default_nettype wire

// >>> testbench/sysref_output_phase_config_test.sv
// Self-checking bench for the aux output and phase configuration block
`timescale 1ns/1ps
`default_nettype none
module sysref_output_phase_config_test;
   localparam logic [7:0] A_BA = spoc_pkg::ADDR_BANK_A;
   localparam logic [7:0] A_BB = spoc_pkg::ADDR_BANK_B;
   localparam logic [7:0] A_AUX = spoc_pkg::ADDR_AUX_CFG;
   localparam logic [7:0] A_SR = spoc_pkg::ADDR_SR_CFG;
   localparam logic [7:0] A_CMD = spoc_pkg::ADDR_CMD;
   localparam int LIMIT = 10000;
   logic clk_in, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, clear_q;
   logic [7:0] wb_adr, swing;
   logic [3:0] wb_sel, aux, buf_on, dly_pwr, fine_buf;
   logic [31:0] wb_dat, rd_dat, rd_q;
   logic [1:0] dev_clk;
   int bad_count, checked, cyc_n, seed;

   spoc_top u_spoc_top (.clk_in(clk_in), .reset_n_in(reset_n),
      .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
      .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
      .wb_dat_out(rd_dat), .wb_ack_out(wb_ack),
      .device_clock_output_out(dev_clk), .aux_reference_output_out(aux),
      .aux_buffer_on_out(buf_on), .aux_swing_out(swing),
      .aux_delay_powered_out(dly_pwr), .aux_fine_buffer_out(fine_buf));
   spoc_conv_model u_conv (.clk_in(clk_in), .clear_in(clear_q),
      .line_in({dev_clk, aux}), .buffer_on_in(buf_on));

   // ============================================================
   // Clock, timeout and reporting
   // ============================================================
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc_n++;
      if (cyc_n == LIMIT) begin
         bad_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // ============================================================
   // Wishbone classic master
   // ============================================================
   task automatic xfer(logic we, logic [7:0] adr, logic [31:0] d);
      int n;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hF;
      wb_dat <= d;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         check("bus answer", 0, 1);
      end
      rd_q = rd_dat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wr(logic [7:0] adr, logic [31:0] d);
      xfer(1'b1, adr, d);
   endtask
   task automatic clr();
      clear_q <= 1'b1;
      @(posedge clk_in);
      clear_q <= 1'b0;
   endtask
   task automatic measure(int n);
      clr();
      // One extra edge: counts read here lag the model by one edge
      repeat (n + 1) @(posedge clk_in);
   endtask

   // ============================================================
   // Main sequence
   // ============================================================
   initial begin
      int d, n, t;
      logic [31:0] v;
      clk_in = 0;
      reset_n = 0;
      wb_cyc = 0;
      wb_stb = 0;
      wb_we = 0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat = 32'h0;
      clear_q = 0;
      bad_count = 0;
      checked = 0;
      cyc_n = 0;
      seed = 23;
      repeat (12) @(posedge clk_in);
      reset_n <= 1'b1;
      @(posedge clk_in);
      xfer(0, A_AUX, 0);
      check("aux reset", rd_q, 32'h10101010);
      xfer(0, A_BA, 0);
      check("bank reset", rd_q & 32'h3F7F, 32'h1);
      xfer(0, A_SR, 0);
      check("sysref reset", rd_q & 32'hFF1F, 32'h100);
      for (int k = 0; k < 4; k++) begin
         v = $random(seed);
         wr(A_AUX, v);
         xfer(0, A_AUX, 0);
         check("aux readback", rd_q, v);
      end
      wr(8'h1C, v);
      xfer(0, 8'h1C, 0);
      check("unmapped", rd_q, 0);
      xfer(0, A_CMD, 0);
      check("command read", rd_q, 0);
      $display("test registers done");
      wr(A_BA, 32'h4);
      for (int c = 0; c < 16; c++) begin
         wr(A_AUX, {24'h101010, 3'b0, c[3], c[1:0], c[2], 1'b0});
         measure(16);
         t = (c[2] && c[1:0] != 0) ? 4 : 0;
         check("buffer on", buf_on[0], c[1:0] != 0);
         check("swing", swing[1:0], c[1:0]);
         check("delay power", dly_pwr[0], !c[3]);
         check("aux edges", u_conv.rises[0], t);
         check("bank edges", u_conv.rises[4], 4);
         if (t == 0) begin
            check("aux low", aux[0], 0);
         end
      end
      $display("test drive table done");
      wr(A_AUX, 32'h16161616); // Host parks delays
      wr(A_BB, 32'd100);
      for (int k = 0; k < 4; k++) begin
         d = k == 0 ? 0 : k == 1 ? 1 : k == 2 ? 63 : {$random(seed)} % 64;
         wr(A_BA, (d << 8) | 100);
         wr(A_CMD, 32'h1);
         repeat (80) @(posedge clk_in);
         measure(110);
         t = u_conv.first[4] - u_conv.first[5];
         check("coarse clock", (t + 100) % 100, d);
         t = u_conv.first[0] - u_conv.first[2];
         check("coarse aux", (t + 100) % 100, d);
      end
      wr(A_BA, 32'h4);
      wr(A_BB, 32'h8);
      wr(A_CMD, 32'h1);
      repeat (20) @(posedge clk_in);
      measure(40);
      check("common edges", u_conv.both, 5);
      $display("test coarse delay done");
      wr(A_SR, 32'h101);
      wr(A_CMD, 32'h2);
      for (int f = 0; f < 8; f++) begin
         wr(A_AUX, {16'h1010, f[2:0], 5'h07, 8'h07});
         repeat (10) @(posedge clk_in);
         measure(70);
         t = u_conv.first[1] - u_conv.first[0];
         check("fine step", (t + 64) % 64, f >> 1);
         check("fine buffer", fine_buf[1:0], {f[0], 1'b0});
         check("delay awake", dly_pwr[1:0], 2'b11);
      end
      $display("test fine delay done");
      wr(A_AUX, 32'h10101007); // Host setup
      for (int k = 0; k < 2; k++) begin
         n = k ? 2 + {$random(seed)} % 4 : 1;
         wr(A_SR, n << 8);
         repeat (200) @(posedge clk_in);
         check("asleep before", buf_on[0], 0);
         clr();
         wr(A_CMD, 32'h2);
         repeat (3) @(posedge clk_in);
         check("woken", buf_on[0], 1);
         xfer(0, spoc_pkg::ADDR_STATUS, 0);
         check("status run", rd_q[1:0], 2'b11);
         repeat (64 * (n + 1)) @(posedge clk_in);
         check("pulse count", u_conv.rises[0], n);
         check("asleep after", buf_on[0], 0);
         xfer(0, spoc_pkg::ADDR_STATUS, 0);
         check("status idle", rd_q & 32'hFF03, 0);
      end
      $display("test counted pulses done");
      summarize();
   end
endmodule // sysref_output_phase_config_test
`default_nettype wire
